// ===== cmd_merge_pkg.sv
// constants and types shared by the command source merge block
package cmd_merge_pkg;

    // ==========================================================
    // source selector coding
    // ==========================================================
    typedef enum logic [1:0] {
        SRC_TERMINAL = 2'h0,
        SRC_SERIAL   = 2'h1,
        SRC_AND      = 2'h2,
        SRC_OR       = 2'h3
    } src_sel_t;

    // reset values of the three selectors
    localparam src_sel_t DIR_SEL_RESET    = SRC_TERMINAL;
    localparam src_sel_t BANK_SEL_RESET   = SRC_OR;
    localparam src_sel_t PRESET_SEL_RESET = SRC_OR;

    // ==========================================================
    // widths and preset count
    // ==========================================================
    localparam int CODE_W      = 2;
    localparam int NUM_W       = 3;
    localparam int CTRL_W      = 16;
    localparam int PRESET_W    = 16;
    localparam int PRESET_CNT  = 4;

    // ==========================================================
    // serial control word field positions
    // ==========================================================
    localparam int CW_DIR_BIT    = 15;
    localparam int CW_BANK_LSB   = 13;
    localparam int CW_PRESET_LSB = 8;

    // ==========================================================
    // reset values of registered state, and the number offset
    // ==========================================================
    localparam logic                  DIR_RESET      = 1'h0;
    localparam logic [CODE_W-1:0]     CODE_RESET     = 2'h0;
    localparam logic [NUM_W-1:0]      NUM_RESET      = 3'h1;
    localparam logic [NUM_W-1:0]      NUM_OFFSET     = 3'h1;
    localparam logic [PRESET_W-1:0]   PRESET_RESET   = 16'h0000;

endpackage : cmd_merge_pkg

// ===== merge_if.sv
// interface carrying one terminal/serial pair to a merge unit
`timescale 1ns/1ns
interface merge_if #(
    parameter int W = 2
);
    logic [W-1:0]           term;
    logic [W-1:0]           bus;
    cmd_merge_pkg::src_sel_t sel;
    logic [W-1:0]           merged;

    modport src  (output term, output bus, output sel, input merged);
    modport unit (input term, input bus, input sel, output merged);
endinterface : merge_if

// ===== merge_unit.sv
// bitwise source merge: terminal, serial, and or or
`timescale 1ns/1ns
module merge_unit #(
    parameter int W = 2
) (
    merge_if.unit m
);

    // ==========================================================
    // merge
    // ==========================================================
    // serial and and modes require the bus bit, and mode also the terminal
    always_comb begin
        unique case (m.sel)
            cmd_merge_pkg::SRC_TERMINAL: m.merged = m.term;
            cmd_merge_pkg::SRC_SERIAL:   m.merged = m.bus;
            cmd_merge_pkg::SRC_AND:      m.merged = m.term & m.bus;
            cmd_merge_pkg::SRC_OR:       m.merged = m.term | m.bus;
        endcase
    end

endmodule : merge_unit

// ===== preset_store.sv
// four preset reference values with a registered read port
`timescale 1ns/1ns
module preset_store (
    input  wire logic                                   clk_sys,
    input  wire logic                                   rst,
    input  wire logic                                   wr_en,
    input  wire logic [cmd_merge_pkg::CODE_W-1:0]       wr_index,
    input  wire logic [cmd_merge_pkg::PRESET_W-1:0]     wr_data,
    input  wire logic [cmd_merge_pkg::CODE_W-1:0]       rd_index,
    output logic      [cmd_merge_pkg::PRESET_W-1:0]     rd_data
);

    // ==========================================================
    // storage, one entry per preset
    // ==========================================================
    logic [cmd_merge_pkg::PRESET_W-1:0] entry [cmd_merge_pkg::PRESET_CNT];
    logic [cmd_merge_pkg::PRESET_W-1:0] next_rd_data;

    genvar gi;
    generate
        for (gi = 0; gi < cmd_merge_pkg::PRESET_CNT; gi++) begin : g_entry
            logic [cmd_merge_pkg::PRESET_W-1:0] next_entry;
            // write hits only the addressed entry
            always_comb begin
                next_entry = entry[gi];
                if (wr_en && (int'(wr_index) == gi)) begin
                    next_entry = wr_data;
                end
            end
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    entry[gi] <= cmd_merge_pkg::PRESET_RESET;
                end else begin
                    entry[gi] <= next_entry;
                end
            end
        end
    endgenerate

    // ==========================================================
    // registered read
    // ==========================================================
    // old data on a same-cycle write: simpler than a bypass
    always_comb begin
        next_rd_data = entry[rd_index];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_data <= cmd_merge_pkg::PRESET_RESET;
        end else begin
            rd_data <= next_rd_data;
        end
    end

endmodule : preset_store

// ===== command_source_merge.sv
// command source merge: direction, active setup and preset selection
//
// Operation
// - terminal mode, direction follows terminal only
// - serial mode, direction follows bus bit only
// - and mode, counter-clockwise needs both ones
// - or mode, counter-clockwise needs either one
// - setup and preset selectors, default or
// - terminal mode: number is terminal code plus one
// - serial mode: number is bus code plus one
// - and mode: number is codes anded plus one
// - or mode: number is codes ored plus one
// - setup number chooses active stored setup
// - preset number chooses one of four presets
// - serial needs bus command, and needs terminal too
// - direction selector resets to terminal mode
`timescale 1ns/1ns
module command_source_merge (
    input  wire logic                                   clk_sys,
    input  wire logic                                   rst,
    // terminal inputs
    input  wire logic                                   direction_terminal_in,
    input  wire logic [cmd_merge_pkg::CODE_W-1:0]       bank_terminal_in,
    input  wire logic [cmd_merge_pkg::CODE_W-1:0]       preset_terminal_in,
    // serial control word
    input  wire logic [cmd_merge_pkg::CTRL_W-1:0]       ctrl_word,
    input  wire logic                                   ctrl_word_valid,
    // selector configuration
    input  wire logic                                   sel_wr_en,
    input  wire cmd_merge_pkg::src_sel_t                direction_source_sel_in,
    input  wire cmd_merge_pkg::src_sel_t                config_bank_source_sel_in,
    input  wire cmd_merge_pkg::src_sel_t                preset_speed_source_sel_in,
    // preset value loading
    input  wire logic                                   preset_wr_en,
    input  wire logic [cmd_merge_pkg::CODE_W-1:0]       preset_wr_index,
    input  wire logic [cmd_merge_pkg::PRESET_W-1:0]     preset_wr_data,
    // results
    output logic                                        run_ccw,
    output logic      [cmd_merge_pkg::NUM_W-1:0]        active_setup_num,
    output logic      [cmd_merge_pkg::NUM_W-1:0]        preset_ref_num,
    output logic      [cmd_merge_pkg::PRESET_W-1:0]     preset_ref_value,
    // selector read-back
    output cmd_merge_pkg::src_sel_t                     direction_source_sel,
    output cmd_merge_pkg::src_sel_t                     config_bank_source_sel,
    output cmd_merge_pkg::src_sel_t                     preset_speed_source_sel
);

    // ==========================================================
    // declarations
    // ==========================================================
    cmd_merge_pkg::src_sel_t                 next_direction_source_sel;
    cmd_merge_pkg::src_sel_t                 next_config_bank_source_sel;
    cmd_merge_pkg::src_sel_t                 next_preset_speed_source_sel;
    logic                                    bus_dir;
    logic [cmd_merge_pkg::CODE_W-1:0]        bus_bank;
    logic [cmd_merge_pkg::CODE_W-1:0]        bus_preset;
    logic                                    next_bus_dir;
    logic [cmd_merge_pkg::CODE_W-1:0]        next_bus_bank;
    logic [cmd_merge_pkg::CODE_W-1:0]        next_bus_preset;
    logic                                    next_run_ccw;
    logic [cmd_merge_pkg::NUM_W-1:0]         next_active_setup_num;
    logic [cmd_merge_pkg::NUM_W-1:0]         next_preset_ref_num;

    merge_if #(.W(1))                     dir_if ();
    merge_if #(.W(cmd_merge_pkg::CODE_W)) bank_if ();
    merge_if #(.W(cmd_merge_pkg::CODE_W)) preset_if ();

    // ==========================================================
    // source selectors
    // ==========================================================
    // all three load together; software rewrites the full set
    always_comb begin
        next_direction_source_sel    = direction_source_sel;
        next_config_bank_source_sel  = config_bank_source_sel;
        next_preset_speed_source_sel = preset_speed_source_sel;
        if (sel_wr_en) begin
            next_direction_source_sel    = direction_source_sel_in;
            next_config_bank_source_sel  = config_bank_source_sel_in;
            next_preset_speed_source_sel = preset_speed_source_sel_in;
        end
    end

    // defaults: direction from terminal, setup and preset by or
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            direction_source_sel    <= cmd_merge_pkg::DIR_SEL_RESET;
            config_bank_source_sel  <= cmd_merge_pkg::BANK_SEL_RESET;
            preset_speed_source_sel <= cmd_merge_pkg::PRESET_SEL_RESET;
        end else begin
            direction_source_sel    <= next_direction_source_sel;
            config_bank_source_sel  <= next_config_bank_source_sel;
            preset_speed_source_sel <= next_preset_speed_source_sel;
        end
    end

    // ==========================================================
    // serial control word fields
    // ==========================================================
    // fields are held between words so a half-updated word never leaks
    always_comb begin
        next_bus_dir    = bus_dir;
        next_bus_bank   = bus_bank;
        next_bus_preset = bus_preset;
        if (ctrl_word_valid) begin
            next_bus_dir    = ctrl_word[cmd_merge_pkg::CW_DIR_BIT];
            next_bus_bank   = ctrl_word[cmd_merge_pkg::CW_BANK_LSB +: cmd_merge_pkg::CODE_W];
            next_bus_preset = ctrl_word[cmd_merge_pkg::CW_PRESET_LSB +: cmd_merge_pkg::CODE_W];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bus_dir    <= cmd_merge_pkg::DIR_RESET;
            bus_bank   <= cmd_merge_pkg::CODE_RESET;
            bus_preset <= cmd_merge_pkg::CODE_RESET;
        end else begin
            bus_dir    <= next_bus_dir;
            bus_bank   <= next_bus_bank;
            bus_preset <= next_bus_preset;
        end
    end

    // ==========================================================
    // merge units
    // ==========================================================
    // one generic unit per function keeps the four modes identical
    assign dir_if.term    = direction_terminal_in;
    assign dir_if.bus     = bus_dir;
    assign dir_if.sel     = direction_source_sel;
    assign bank_if.term   = bank_terminal_in;
    assign bank_if.bus    = bus_bank;
    assign bank_if.sel    = config_bank_source_sel;
    assign preset_if.term = preset_terminal_in;
    assign preset_if.bus  = bus_preset;
    assign preset_if.sel  = preset_speed_source_sel;

    merge_unit #(.W(1)) u_dir_merge (
        .m (dir_if.unit)
    );

    merge_unit #(.W(cmd_merge_pkg::CODE_W)) u_bank_merge (
        .m (bank_if.unit)
    );

    merge_unit #(.W(cmd_merge_pkg::CODE_W)) u_preset_merge (
        .m (preset_if.unit)
    );

    // ==========================================================
    // result registers
    // ==========================================================
    // code 00 means number 1, so the offset is added here, not in the unit
    always_comb begin
        next_run_ccw          = dir_if.merged;
        next_active_setup_num = {1'b0, bank_if.merged} + cmd_merge_pkg::NUM_OFFSET;
        next_preset_ref_num   = {1'b0, preset_if.merged} + cmd_merge_pkg::NUM_OFFSET;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            run_ccw          <= cmd_merge_pkg::DIR_RESET;
            active_setup_num <= cmd_merge_pkg::NUM_RESET;
            preset_ref_num   <= cmd_merge_pkg::NUM_RESET;
        end else begin
            run_ccw          <= next_run_ccw;
            active_setup_num <= next_active_setup_num;
            preset_ref_num   <= next_preset_ref_num;
        end
    end

    // ==========================================================
    // preset value lookup
    // ==========================================================
    // read index is the merged code, so the value lines up with the number
    preset_store u_preset_store (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .wr_en    (preset_wr_en),
        .wr_index (preset_wr_index),
        .wr_data  (preset_wr_data),
        .rd_index (preset_if.merged),
        .rd_data  (preset_ref_value)
    );

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // a serial word is taken, then the merged result appears two edges later
    sequence s_word_taken;
        ctrl_word_valid ##1 !rst;
    endsequence

    a_dir_terminal_mode: assert property (
        (direction_source_sel == cmd_merge_pkg::SRC_TERMINAL)
        |=> (run_ccw == $past(direction_terminal_in)))
        else $error("direction ignores terminal in terminal mode");

    a_dir_serial_mode: assert property (
        (direction_source_sel == cmd_merge_pkg::SRC_SERIAL)
        |=> (run_ccw == $past(bus_dir)))
        else $error("direction ignores bus bit in serial mode");

    a_dir_and_mode: assert property (
        (direction_source_sel == cmd_merge_pkg::SRC_AND)
        |=> (run_ccw == ($past(direction_terminal_in) && $past(bus_dir))))
        else $error("direction wrong in and mode");

    a_dir_or_mode: assert property (
        (direction_source_sel == cmd_merge_pkg::SRC_OR)
        |=> (run_ccw == ($past(direction_terminal_in) || $past(bus_dir))))
        else $error("direction wrong in or mode");

    a_sel_reset_values: assert property (
        $fell(rst) |-> (config_bank_source_sel == cmd_merge_pkg::SRC_OR)
                    && (preset_speed_source_sel == cmd_merge_pkg::SRC_OR))
        else $error("setup or preset selector not at or after reset");

    a_dir_sel_reset: assert property (
        $fell(rst) |-> (direction_source_sel == cmd_merge_pkg::SRC_TERMINAL)
                    && (run_ccw == 1'b0))
        else $error("direction selector not terminal after reset");

    a_setup_terminal_num: assert property (
        (config_bank_source_sel == cmd_merge_pkg::SRC_TERMINAL)
        |=> (active_setup_num == {1'b0, $past(bank_terminal_in)} + 3'h1))
        else $error("setup number not terminal code plus one");

    a_setup_serial_num: assert property (
        (config_bank_source_sel == cmd_merge_pkg::SRC_SERIAL)
        |=> (active_setup_num == {1'b0, $past(bus_bank)} + 3'h1))
        else $error("setup number not bus code plus one");

    a_preset_and_num: assert property (
        (preset_speed_source_sel == cmd_merge_pkg::SRC_AND)
        |=> (preset_ref_num == {1'b0, $past(preset_terminal_in) & $past(bus_preset)} + 3'h1))
        else $error("preset number wrong in and mode");

    a_preset_or_num: assert property (
        (preset_speed_source_sel == cmd_merge_pkg::SRC_OR)
        |=> (preset_ref_num == {1'b0, $past(preset_terminal_in) | $past(bus_preset)} + 3'h1))
        else $error("preset number wrong in or mode");

    a_setup_num_range: assert property (
        (active_setup_num >= 3'h1) && (active_setup_num <= 3'h4))
        else $error("active setup number out of range");

    a_preset_num_range: assert property (
        (preset_ref_num >= 3'h1) && (preset_ref_num <= 3'h4))
        else $error("preset number out of range");

    a_bus_field_hold: assert property (
        !ctrl_word_valid |=> $stable(bus_dir) && $stable(bus_bank) && $stable(bus_preset))
        else $error("bus fields changed without a control word");

    a_serial_word_path: assert property (
        (s_word_taken and (direction_source_sel == cmd_merge_pkg::SRC_SERIAL)
         and !sel_wr_en)
        |=> (run_ccw == $past(ctrl_word[cmd_merge_pkg::CW_DIR_BIT], 2)))
        else $error("serial direction command not applied two edges later");

    a_sel_load: assert property (
        sel_wr_en |=> (direction_source_sel == $past(direction_source_sel_in))
                   && (config_bank_source_sel == $past(config_bank_source_sel_in))
                   && (preset_speed_source_sel == $past(preset_speed_source_sel_in)))
        else $error("selector write not taken");

endmodule : command_source_merge

// ===== fieldbus_master_model.sv
// fieldbus master model: sends control words after an adjustable delay
`timescale 1ns/1ns
module fieldbus_master_model (
    input  wire logic                               clk_sys,
    input  wire logic                               rst,
    input  wire logic                               send,
    input  wire logic                               dir,
    input  wire logic [cmd_merge_pkg::CODE_W-1:0]   bank_code,
    input  wire logic [cmd_merge_pkg::CODE_W-1:0]   preset_code,
    input  wire logic [3:0]                         gap,
    output logic      [cmd_merge_pkg::CTRL_W-1:0]   ctrl_word,
    output logic                                    ctrl_word_valid,
    output logic                                    sent
);
    logic [3:0]                       wait_cnt;
    logic                             pending;
    logic [cmd_merge_pkg::CTRL_W-1:0] filler;
    logic [cmd_merge_pkg::CTRL_W-1:0] next_word;

    // ==========================================================
    // word assembly
    // ==========================================================
    // spare bits wander so the block cannot lean on them
    always_comb begin
        next_word = filler;
        next_word[cmd_merge_pkg::CW_DIR_BIT] = dir;
        next_word[cmd_merge_pkg::CW_BANK_LSB +: 2] = bank_code;
        next_word[cmd_merge_pkg::CW_PRESET_LSB +: 2] = preset_code;
    end

    // ==========================================================
    // sending
    // ==========================================================
    // fields stay put between words; valid is a one-cycle strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wait_cnt <= 4'h0;
            pending <= 1'b0;
            filler <= 16'h5A3C;
            ctrl_word <= 16'h0000;
            ctrl_word_valid <= 1'b0;
            sent <= 1'b0;
        end else begin
            filler <= {filler[14:0], ~filler[15]};
            ctrl_word_valid <= 1'b0;
            sent <= 1'b0;
            if (send) begin
                pending <= 1'b1;
                wait_cnt <= gap;
            end else if (pending && wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end else if (pending) begin
                pending <= 1'b0;
                ctrl_word <= next_word;
                ctrl_word_valid <= 1'b1;
                sent <= 1'b1;
            end
        end
    end
endmodule : fieldbus_master_model

// ===== tb_command_source_merge.sv
// self-checking testbench for the command source merge block
`timescale 1ns/1ns
module tb_command_source_merge;
    logic                    clk_sys = 1'b0;
    logic                    rst = 1'b1;
    logic                    direction_terminal_in = 1'b0;
    logic [1:0]              bank_terminal_in = 2'h0;
    logic [1:0]              preset_terminal_in = 2'h0;
    logic [15:0]             ctrl_word;
    logic                    ctrl_word_valid;
    logic                    sel_wr_en = 1'b0;
    cmd_merge_pkg::src_sel_t dir_sel_in = cmd_merge_pkg::SRC_TERMINAL;
    cmd_merge_pkg::src_sel_t bank_sel_in = cmd_merge_pkg::SRC_TERMINAL;
    cmd_merge_pkg::src_sel_t preset_sel_in = cmd_merge_pkg::SRC_TERMINAL;
    logic                    preset_wr_en = 1'b0;
    logic [1:0]              preset_wr_index = 2'h0;
    logic [15:0]             preset_wr_data = 16'h0000;
    logic                    run_ccw;
    logic [2:0]              active_setup_num;
    logic [2:0]              preset_ref_num;
    logic [15:0]             preset_ref_value;
    cmd_merge_pkg::src_sel_t dir_sel;
    cmd_merge_pkg::src_sel_t bank_sel;
    cmd_merge_pkg::src_sel_t preset_sel;
    logic                    fb_send = 1'b0;
    logic                    fb_dir = 1'b0;
    logic [1:0]              fb_bank = 2'h0;
    logic [1:0]              fb_preset = 2'h0;
    logic [3:0]              fb_gap = 4'h0;
    logic                    fb_sent;
    int                      mismatches = 0;
    int                      total_checks = 0;
    logic [15:0]             vals [4] = '{16'h1234, 16'hBEEF, 16'h0F0F, 16'hC001};

    // ==========================================================
    // clock and instances
    // ==========================================================
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    command_source_merge i_command_source_merge (
        .clk_sys(clk_sys), .rst(rst), .direction_terminal_in(direction_terminal_in),
        .bank_terminal_in(bank_terminal_in), .preset_terminal_in(preset_terminal_in),
        .ctrl_word(ctrl_word), .ctrl_word_valid(ctrl_word_valid), .sel_wr_en(sel_wr_en),
        .direction_source_sel_in(dir_sel_in), .config_bank_source_sel_in(bank_sel_in),
        .preset_speed_source_sel_in(preset_sel_in), .preset_wr_en(preset_wr_en),
        .preset_wr_index(preset_wr_index), .preset_wr_data(preset_wr_data),
        .run_ccw(run_ccw), .active_setup_num(active_setup_num),
        .preset_ref_num(preset_ref_num), .preset_ref_value(preset_ref_value),
        .direction_source_sel(dir_sel), .config_bank_source_sel(bank_sel),
        .preset_speed_source_sel(preset_sel));

    fieldbus_master_model i_fieldbus_master_model (
        .clk_sys(clk_sys), .rst(rst), .send(fb_send), .dir(fb_dir), .bank_code(fb_bank),
        .preset_code(fb_preset), .gap(fb_gap), .ctrl_word(ctrl_word),
        .ctrl_word_valid(ctrl_word_valid), .sent(fb_sent));

    // ==========================================================
    // reference and compare helpers
    // ==========================================================
    // expected merged code, worked out independently of the design
    function automatic logic [1:0] merge2(input int s, input logic [1:0] t, input logic [1:0] b);
        case (s)
            0: return t;
            1: return b;
            2: return t & b;
            default: return t | b;
        endcase
    endfunction : merge2

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task automatic check_bit(input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check_bit

    task automatic check_num(input logic [2:0] exp, input logic [2:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check_num

    task automatic check_val(input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check_val

    // loads selectors and terminals, has the master send a word, waits for the result
    task automatic apply(input int sd, input int sb, input int sp, input logic dt,
                         input logic [1:0] bt, input logic [1:0] pt, input logic bd,
                         input logic [1:0] bb, input logic [1:0] bp, input logic [3:0] g);
        int n;
        n = 0;
        @(posedge clk_sys);
        sel_wr_en <= 1'b1;
        dir_sel_in <= cmd_merge_pkg::src_sel_t'(sd[1:0]);
        bank_sel_in <= cmd_merge_pkg::src_sel_t'(sb[1:0]);
        preset_sel_in <= cmd_merge_pkg::src_sel_t'(sp[1:0]);
        direction_terminal_in <= dt;
        bank_terminal_in <= bt;
        preset_terminal_in <= pt;
        fb_dir <= bd;
        fb_bank <= bb;
        fb_preset <= bp;
        fb_gap <= g;
        fb_send <= 1'b1;
        @(posedge clk_sys);
        sel_wr_en <= 1'b0;
        fb_send <= 1'b0;
        #1;
        while (fb_sent !== 1'b1) begin
            n++;
            if (n > 40) begin
                mismatches++;
                stop_test();
            end
            @(posedge clk_sys);
            #1;
        end
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : apply

    // ==========================================================
    // scenarios
    // ==========================================================
    // reset held three cycles, defaults checked at the releasing edge
    task automatic test_reset();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check_val(16'h0000, {14'h0, dir_sel});
        check_val(16'h0003, {14'h0, bank_sel});
        check_val(16'h0003, {14'h0, preset_sel});
        check_bit(1'b0, run_ccw);
        check_num(3'h1, active_setup_num);
        check_num(3'h1, preset_ref_num);
        check_val(16'h0000, preset_ref_value);
        $display("test_reset done");
    endtask : test_reset

    // every mode against all four terminal and bus combinations, slow master too
    task automatic test_direction();
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 4; k++) begin
                apply(s, 3, 3, k[1], 2'h0, 2'h0, k[0], 2'h0, 2'h0, 4'(k * 3));
                check_bit(merge2(s, {1'b0, k[1]}, {1'b0, k[0]}) == 2'h1, run_ccw);
            end
        end
        $display("test_direction done");
    endtask : test_direction

    // full tables; the two paths get crossed codes and different modes
    task automatic test_numbers();
        logic [1:0] t;
        logic [1:0] b;
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 16; k++) begin
                b = k[3:2];
                t = k[1:0];
                apply(m, m, 3 - m, k[0], t, b, k[3], b, t, 4'h0);
                check_num({1'b0, merge2(m, t, b)} + 3'h1, active_setup_num);
                check_num({1'b0, merge2(3 - m, b, t)} + 3'h1, preset_ref_num);
            end
            check_val(16'(m), {14'h0, bank_sel});
            check_val(16'(3 - m), {14'h0, preset_sel});
        end
        $display("test_numbers done");
    endtask : test_numbers

    // back-to-back writes, then each entry picked by its number, then a live rewrite
    task automatic test_presets();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            preset_wr_en <= 1'b1;
            preset_wr_index <= 2'(i);
            preset_wr_data <= vals[i];
        end
        @(posedge clk_sys);
        preset_wr_en <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apply(0, 0, 0, 1'b0, 2'h0, 2'(i), 1'b0, 2'h0, 2'(3 - i), 4'h1);
            check_num(3'(i + 1), preset_ref_num);
            check_val(vals[i], preset_ref_value);
        end
        @(posedge clk_sys);
        preset_wr_en <= 1'b1;
        preset_wr_index <= 2'h3;
        preset_wr_data <= 16'h7E81;
        @(posedge clk_sys);
        preset_wr_en <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        check_val(16'h7E81, preset_ref_value);
        $display("test_presets done");
    endtask : test_presets

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        test_reset();
        test_direction();
        test_numbers();
        test_presets();
        test_reset();
        stop_test();
    end
endmodule : tb_command_source_merge
